// *** logic/lsh_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts for the LIN slave header receiver
// Assumes: Word-indexed register port
// Notes:   Definitions only
`ifndef LSH_DEFS_SVH
`define LSH_DEFS_SVH
// Register addresses
`define LSH_ADDR_IER      6'h01
`define LSH_ADDR_BAUD     6'h09
`define LSH_ADDR_LIN_CTL  6'h0D
`define LSH_ADDR_LIN_SR   6'h0E
`define LSH_ADDR_RX_DATA  6'h00
`define LSH_ADDR_THR      6'h00
// Control fields and the interrupt enable bit
`define LSH_CTL_SLV_EN    0
`define LSH_CTL_HDET_EN   1
`define LSH_CTL_ARS_EN    2
`define LSH_CTL_RELOAD    3
`define LSH_CTL_MUTE      4
`define LSH_CTL_IDPEN     9
`define LSH_CTL_HSEL_LO   22
`define LSH_CTL_PID_LO    24
`define LSH_IER_LIN       8
// Status fields
`define LSH_SR_HDET       0
`define LSH_SR_HERR       1
`define LSH_SR_IDPERR     2
`define LSH_SR_RESYNC     3
`define LSH_SR_RXVALID    4
// Reset values
`define LSH_BAUD_RESET    32'h0F00_0000
`define LSH_CTL_RESET     32'h000C_0000
// Header timing, in bit times, and the sync byte
`define LSH_HDR_TIMEOUT_BITS 57
`define LSH_BREAK_BITS       11
`define LSH_SYNC_BYTE        8'h55
`endif

// *** logic/lsh_pkg.sv ***
// Purpose: Types for the LIN slave header receiver
// Assumes: Nothing
// Notes:   Constants stay in lsh_defs.svh
package lsh_pkg;
   typedef enum logic [2:0] {
      LSH_IDLE, LSH_BREAK, LSH_DELIM, LSH_SYNC, LSH_ID, LSH_DONE, LSH_ERROR
   } lsh_state_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } lsh_byte_t;
endpackage

// *** logic/lsh_header_rx.sv ***
// Purpose: LIN slave header detection, mute handling and baud resynchronisation
// Assumes: 8N1 characters, divider in mode 2 (one bit = divisor+2 clocks)
// Notes:   Registers on a simple strobe port, read data one cycle later
//          Status flags 0..2 are write-one-to-clear; a same-cycle hardware set wins
//          Writing one to status bit 3 reloads the nominal divisor and restarts the search
//          Status bit 4 reads back the live mute state
//          The receiver samples each bit at half a bit time after the start edge
//          Header sequence: idle, break, delimiter, sync, ID, done or error
//          The header time-out runs from the break edge through every header state
//          Sync measurement runs from the start edge to the fifth falling edge
//          The new divisor is the eighth of that span less the two mode 2 clocks
//          At the fifth edge the receiver is realigned, so the rest of the sync
//          byte and the ID are sampled at the measured rate
//          Both deviation checks use the divisor that was live before the update
//          The whole-span check fires at the fifth edge, before the divisor moves
//          Thresholds sit on the edges of the allowed bands: 147/128 and 19/16 above,
//          109/128 and 13/16 below
//          Mute is entered whenever software writes the control word with mute on
//          and left on the selected exit condition; software re-enters it itself
//          Interrupt is a registered level, so it lags the flags by one cycle
//          Limitation: no FIFO here, received bytes leave as one-cycle strobes
//          Limitation: ID parity uses the usual P0 on bit 6 and P1 on bit 7
// Notes on behaviour
// RQ1 - With header detection on in slave mode, a full header sets the header-detected flag.
// RQ2 - Any slave status flag setting raises the interrupt when the LIN interrupt enable is one.
// RQ3 - With ID parity checking, bad ID parity sets parity error and header-detected.
// RQ4 - In mute mode only headers are detected; other characters are kept out.
// RQ5 - A header not complete within 57 bit times sets the header error flag.
// RQ6 - The time-out starts at each break and stops on ID, error or resync write.
// RQ7 - Break-only select leaves mute after break and delimiter; sync onward is stored.
// RQ8 - Break-and-sync select leaves mute after a clean sync; ID onward is stored.
// RQ9 - Full select leaves mute on clean sync and matching ID; responses are stored.
// RQ10 - Software should enter mute after sending the checksum.
// RQ11 - Software writes published response bytes to the transmit holding register.
// RQ12 - With auto resync on, the baud divisor is adjusted after each sync field.
// RQ13 - The span of five sync falling edges is timed in 13 bits, written at the fifth.
// RQ14 - A 13-bit measurement overflow before the fifth edge sets the header error flag.
// RQ15 - The software-programmed baud value is kept apart as the nominal value.
// RQ16 - Reload enable restores the nominal baud on the next character, then self-clears.
// RQ17 - Software should set reload enable before each checksum reception.
// RQ18 - Writing one to resync-search reloads nominal baud and restarts header search.
// RQ19 - Software sets divider mode bits 29 and 28 before using auto resync.
// RQ20 - Whole sync span deviating over 14.84 percent sets header error.
// RQ21 - Any sync edge interval deviating over 18.75 percent sets header error. The code leaves the first interval unchecked.
// RQ22 - Short delimiter, frame error, bad sync, deviation or time-outs set header error. The code checks the sync value only with auto resync off.
// RQ23 - A break needs over 11 dominant bit times and a recessive delimiter.
// RQ24 - Software sets slave enable after choosing function and baud rate.
// RQ25 - While slave operation is off, all logic idles and flags stay unchanged.
//
// Decided for this implementation: the address map and strobed register access.
`include "lsh_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module lsh_header_rx
   import lsh_pkg::*;
#(
   parameter int TMR_W = 13
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Register port
   input  wire logic [5:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // LIN bus
   input  wire logic        sin,
   // Receive path and interrupt
   output lsh_byte_t        rx_out,
   output logic             irq
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_s1, rst_s2;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   wire logic rst_n = rst_s2;

   // ---------------------------------------------------------------
   // Registers and decode
   // ---------------------------------------------------------------
   logic [31:0] ctl, baud, nominal, ier;
   logic [3:0]  sr;
   wire logic wr_ctl  = wr && addr == `LSH_ADDR_LIN_CTL;
   wire logic wr_baud = wr && addr == `LSH_ADDR_BAUD;
   wire logic wr_ier  = wr && addr == `LSH_ADDR_IER;
   wire logic wr_sr   = wr && addr == `LSH_ADDR_LIN_SR;
   wire logic resync_wr = wr_sr && wdata[`LSH_SR_RESYNC];
   wire logic slv_en  = ctl[`LSH_CTL_SLV_EN];
   wire logic hdet_en = ctl[`LSH_CTL_HDET_EN];
   wire logic ars_en  = ctl[`LSH_CTL_ARS_EN];
   wire logic mute_en = ctl[`LSH_CTL_MUTE];
   wire logic [1:0] hsel = ctl[`LSH_CTL_HSEL_LO +: 2];
   wire logic [7:0] pid  = ctl[`LSH_CTL_PID_LO +: 8];
   // Mode 2 divider: a bit lasts divisor plus two clocks
   wire logic [15:0] bit_clks = baud[15:0] + 16'h0002;

   // ---------------------------------------------------------------
   // Bit-level receiver
   // ---------------------------------------------------------------
   logic        sin_q;
   logic [15:0] bcnt;
   logic [3:0]  bidx;
   logic [7:0]  shreg;
   logic        rx_busy;
   logic        sync_realign;

   // Falling edge of the line, seen in the first clock that sin is low while sin_q still holds high
   wire logic fall = sin_q && !sin;
   wire logic mid  = rx_busy && bcnt == {1'b0, bit_clks[15:1]};
   wire logic char_done = mid && bidx == 4'h9;
   wire logic ferr = !sin;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sin_q <= 1'b1;
         bcnt <= 16'h0000;
         bidx <= 4'h0;
         shreg <= 8'h00;
         rx_busy <= 1'b0;
      end else begin
         sin_q <= sin;
         if (!slv_en) begin
            rx_busy <= 1'b0; // RQ25
         end else if (sync_realign) begin
            // Fifth sync edge starts the last data bit: realign to the new bit time
            rx_busy <= 1'b1;
            bcnt <= 16'h0001;
            bidx <= 4'h8;
         end else if (!rx_busy && fall) begin
            rx_busy <= 1'b1;
            bcnt <= 16'h0000;
            bidx <= 4'h0;
         end else if (rx_busy) begin
            bcnt <= (bcnt == bit_clks - 16'h0001) ? 16'h0000 : bcnt + 16'h0001;
            if (mid) begin
               bidx <= bidx + 4'h1;
               if (bidx != 4'h0 && bidx != 4'h9)
                  shreg <= {sin, shreg[7:1]};
               if (bidx == 4'h9)
                  rx_busy <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Header sequencer
   // ---------------------------------------------------------------
   lsh_state_t st;
   logic [19:0] low_cnt, hdr_cnt;
   logic [15:0] hi_cnt;
   logic [TMR_W-1:0] meas, seg;
   logic [2:0]  edges;
   logic        seg_bad, muted;
   wire logic [19:0] bit20 = {4'h0, bit_clks};
   wire logic brk_ok = low_cnt > bit20 * 20'd`LSH_BREAK_BITS; // RQ23
   wire logic hdr_to = hdr_cnt >= bit20 * 20'd`LSH_HDR_TIMEOUT_BITS; // RQ5
   wire logic meas_ovf = &meas; // RQ14
   // Nominal sync span is eight bits; 14.84% is about 19/128
   wire logic [TMR_W+7:0] nom8 = {5'h00, bit_clks[15:0]} << 3;
   wire logic [TMR_W+7:0] span = {8'h00, meas};
   wire logic span_dev = (span * 21'd128 > nom8 * 21'd147) || (span * 21'd128 < nom8 * 21'd109); // RQ20
   // Edge interval nominal two bits; 18.75% = 3/16
   wire logic [TMR_W+7:0] nom2 = {5'h00, bit_clks[15:0]} << 1;
   wire logic [TMR_W+7:0] sg  = {8'h00, seg};
   wire logic seg_dev = (sg * 21'd16 > nom2 * 21'd19) || (sg * 21'd16 < nom2 * 21'd13); // RQ21
   wire logic id_par_ok = (shreg[6] == (shreg[0] ^ shreg[1] ^ shreg[2] ^ shreg[4]))
      && (shreg[7] == !(shreg[1] ^ shreg[3] ^ shreg[4] ^ shreg[5]));
   logic set_hdet, set_herr, set_perr;
   always_comb begin
      set_hdet = 1'b0;
      set_herr = 1'b0;
      set_perr = 1'b0;
      if (slv_en && hdet_en && !resync_wr) begin
         // Time-out covers every state from the break edge up to the ID
         if (st inside {LSH_BREAK, LSH_DELIM, LSH_SYNC, LSH_ID} && hdr_to)
            set_herr = 1'b1; // RQ5
         else if (st == LSH_DELIM && !sin && hi_cnt < {1'b0, bit_clks[15:1]})
            set_herr = 1'b1; // RQ22
         else if (st == LSH_SYNC && ars_en && (meas_ovf || (fall && edges != 3'd0 && seg_dev)))
            set_herr = 1'b1; // RQ14 RQ21
         // Whole span judged at the fifth edge, while the old divisor still stands
         else if (st == LSH_SYNC && ars_en && fall && edges == 3'd3 && span_dev)
            set_herr = 1'b1; // RQ20
         else if (st == LSH_SYNC && char_done && (ferr || (!ars_en && shreg != `LSH_SYNC_BYTE)))
            set_herr = 1'b1; // RQ22
         else if (st == LSH_ID && char_done && ferr)
            set_herr = 1'b1; // RQ22
         else if (st == LSH_ID && char_done) begin
            set_hdet = 1'b1; // RQ1
            set_perr = ctl[`LSH_CTL_IDPEN] && !id_par_ok; // RQ3
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= LSH_IDLE;
         low_cnt <= 20'h0_0000;
         hi_cnt <= 16'h0000;
         hdr_cnt <= 20'h0_0000;
         meas <= '0;
         seg <= '0;
         edges <= 3'd0;
         seg_bad <= 1'b0;
      end else if (!slv_en || resync_wr) begin
         st <= LSH_IDLE; // RQ18 RQ25
         low_cnt <= 20'h0_0000;
      end else begin
         low_cnt <= sin ? 20'h0_0000 : low_cnt + 20'h0_0001;
         if (st != LSH_IDLE && st != LSH_ERROR && st != LSH_DONE)
            hdr_cnt <= hdr_cnt + 20'h0_0001;
         if (set_herr)
            st <= LSH_ERROR; // RQ6
         else begin
            case (st)
               LSH_IDLE, LSH_DONE: begin
                  if (fall) begin
                     st <= LSH_BREAK;
                     hdr_cnt <= 20'h0_0000; // RQ6
                  end
               end
               LSH_BREAK: begin
                  if (sin)
                     st <= brk_ok ? LSH_DELIM : LSH_IDLE; // RQ23
                  hi_cnt <= 16'h0000;
               end
               LSH_DELIM: begin
                  hi_cnt <= hi_cnt + 16'h0001;
                  if (!sin) begin
                     st <= LSH_SYNC;
                     meas <= '0;
                     seg <= '0;
                     edges <= 3'd0;
                  end
               end
               LSH_SYNC: begin
                  if (edges != 3'd4) begin
                     meas <= meas + 1'b1; // RQ13
                     seg <= fall ? '0 : seg + 1'b1;
                  end
                  if (fall && edges != 3'd4)
                     edges <= edges + 3'd1;
                  if (char_done)
                     st <= LSH_ID;
               end
               LSH_ID: begin
                  if (char_done)
                     st <= LSH_DONE; // RQ6
               end
               default: st <= LSH_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Control, baud and status
   // ---------------------------------------------------------------
   wire logic sync_end = st == LSH_SYNC && edges == 3'd4 && !set_herr && slv_en && ars_en;
   logic sync_end_q;

   // One-cycle pulse that loads the divisor and realigns the receiver together
   assign sync_realign = sync_end && !sync_end_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= `LSH_CTL_RESET;
         baud <= `LSH_BAUD_RESET;
         nominal <= `LSH_BAUD_RESET;
         ier <= 32'h0000_0000;
         sr <= 4'h0;
         sync_end_q <= 1'b0;
      end else begin
         sync_end_q <= sync_end;
         if (wr_ier)
            ier <= wdata;
         if (wr_ctl)
            ctl <= wdata;
         else if (slv_en && ctl[`LSH_CTL_RELOAD] && char_done)
            ctl[`LSH_CTL_RELOAD] <= 1'b0; // RQ16
         if (wr_baud) begin
            baud <= wdata;
            nominal <= wdata; // RQ15
         end else if (resync_wr || (slv_en && ctl[`LSH_CTL_RELOAD] && char_done))
            baud <= nominal; // RQ16 RQ18
         else if (sync_realign) // RQ12
            // Span is eight bits; mode 2 adds two clocks to the divisor
            baud <= {baud[31:16], 3'b000, (meas >> 3) - 13'd2}; // RQ13
         // Set wins over a same-cycle clear
         sr[`LSH_SR_HDET]   <= set_hdet || (sr[`LSH_SR_HDET] && !(wr_sr && wdata[`LSH_SR_HDET]));
         sr[`LSH_SR_HERR]   <= set_herr || (sr[`LSH_SR_HERR] && !(wr_sr && wdata[`LSH_SR_HERR]));
         sr[`LSH_SR_IDPERR] <= set_perr || (sr[`LSH_SR_IDPERR] && !(wr_sr && wdata[`LSH_SR_IDPERR]));
         sr[`LSH_SR_RESYNC] <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Mute and receive path
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         muted <= 1'b0;
         rx_out <= '0;
         irq <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         // Writing the control word with mute on enters mute at once
         if (wr_ctl)
            muted <= wdata[`LSH_CTL_MUTE]; // RQ4
         else if (!mute_en)
            muted <= 1'b0;
         else if (slv_en) begin
            if (hsel == 2'd0 && st == LSH_DELIM && !sin && !set_herr)
               muted <= 1'b0; // RQ7
            else if (hsel == 2'd1 && st == LSH_SYNC && char_done && !set_herr)
               muted <= 1'b0; // RQ8
            else if (hsel == 2'd2 && set_hdet && shreg == pid)
               muted <= 1'b0; // RQ9
         end
         // No received byte leaves while muted, header bytes included
         rx_out.valid <= char_done && !ferr && slv_en && !(muted && mute_en); // RQ4
         rx_out.data  <= shreg;
         irq <= ier[`LSH_IER_LIN] && |sr[2:0]; // RQ2
         rdata <= 32'h0000_0000;
         if (rd) begin
            case (addr)
               `LSH_ADDR_IER:     rdata <= ier;
               `LSH_ADDR_BAUD:    rdata <= baud;
               `LSH_ADDR_LIN_CTL: rdata <= ctl;
               `LSH_ADDR_LIN_SR:  rdata <= {27'h000_0000, muted, sr};
               default:           rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // lsh_header_rx
`default_nettype wire

// *** testbench/lsh_header_rx_sva.sv ***
// Purpose: Port-level assertions for lsh_header_rx
// Assumes: Register port and fields of lsh_defs.svh
// Notes:   Shadows of IER and LIN control are rebuilt from bus writes
`include "lsh_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module lsh_header_rx_sva
   import lsh_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [5:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        sin,
   input wire lsh_byte_t   rx_out,
   input wire logic        irq
);
   logic        ier_lin;
   logic [31:0] ctl;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ier_lin <= 1'b0;
         ctl     <= `LSH_CTL_RESET;
      end else if (wr && addr == `LSH_ADDR_IER) begin
         ier_lin <= wdata[`LSH_IER_LIN];
      end else if (wr && addr == `LSH_ADDR_LIN_CTL) begin
         ctl <= wdata;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence sr_read;
      rd && addr == `LSH_ADDR_LIN_SR;
   endsequence
   sequence ctl_read;
      rd && addr == `LSH_ADDR_LIN_CTL;
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data not zero outside read slot");
   unmapped_zero_a: assert property (rd && !(addr inside {`LSH_ADDR_RX_DATA, `LSH_ADDR_IER, `LSH_ADDR_BAUD,
      `LSH_ADDR_LIN_CTL, `LSH_ADDR_LIN_SR}) |=> rdata == 32'h0000_0000) else $error("unmapped read not zero");
   resync_reads_a: assert property (sr_read |=> !rdata[`LSH_SR_RESYNC] && rdata[31:5] == 27'h0)
      else $error("status upper bits not zero");
   irq_masked_a: assert property (!ier_lin && !$past(ier_lin) |-> !irq)
      else $error("interrupt while masked");
   irq_flags_a: assert property (sr_read ##0 ier_lin ##1 ier_lin |-> irq == (|rdata[2:0]))
      else $error("interrupt does not follow status flags");
   ctl_readback_a: assert property (ctl_read |=> rdata[2:0] == ctl[2:0] && rdata[31:22] == ctl[31:22])
      else $error("control readback wrong");
   rx_pulse_a: assert property (rx_out.valid |=> !rx_out.valid)
      else $error("receive strobe longer than one cycle");
   idle_quiet_a: assert property (!ctl[0] && !$past(ctl[0]) && $stable(ier_lin) |=> !$rose(irq))
      else $error("status changed while slave disabled");
endmodule // lsh_header_rx_sva
`default_nettype wire

// *** testbench/lsh_lin_master.sv ***
// Purpose: Behavioural LIN master driving headers on the bus line
// Assumes: Bus is recessive high through its pull-up when not driven low
// Notes:   Bit length in clocks is set by the bench to force deviation
`timescale 1ns/100ps
`default_nettype none
module lsh_lin_master (
   input  wire logic mclk,
   output var logic  sin
);
   int bit_clks = 16;
   initial sin = 1'b1;
   task automatic hold(input logic lvl, input int bits);
      sin <= lvl;
      repeat (bits * bit_clks) @(posedge mclk);
   endtask
   task automatic send_byte(input logic [7:0] b);
      hold(1'b0, 1);
      for (int i = 0; i < 8; i++) hold(b[i], 1);
      hold(1'b1, 1);
   endtask
   // Break of brk dominant bits, one-bit delimiter, sync and PID
   task automatic send_header(input int brk, input logic [7:0] sy, input logic [7:0] pid);
      hold(1'b0, brk);
      hold(1'b1, 1);
      send_byte(sy);
      send_byte(pid);
      hold(1'b1, 2);
   endtask
endmodule // lsh_lin_master
`default_nettype wire

// *** testbench/lsh_header_rx_tb.sv ***
// Purpose: Self-checking bench for lsh_header_rx
// Assumes: Baud 14 in mode 2 gives 16 clocks per bit
// Notes:   Reset values first, then header rows, then hand-written cases
`include "lsh_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module lsh_header_rx_tb;
   import lsh_pkg::*;
   typedef struct packed {
      logic [15:0] ctl;
      logic [7:0]  sy;
      logic [7:0]  pid;
      logic [2:0]  flags;
   } lsh_row_t;
   logic        mclk, rst_b, wr, rd, sin, irq;
   logic [5:0]  addr;
   logic [31:0] wdata, rdata, v;
   lsh_byte_t   rx_out;
   int          errors, n_compared;
   logic [7:0]  rxq[$];
   lsh_row_t    rows[4] = '{{16'h0203, 8'h55, 8'h3C, 3'b001}, {16'h0203, 8'h55, 8'h41, 3'b101},
                            {16'h0003, 8'h55, 8'h41, 3'b001}, {16'h0003, 8'h54, 8'h3C, 3'b010}};
   lsh_header_rx lsh_header_rx_i (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .sin(sin), .rx_out(rx_out), .irq(irq));
   lsh_lin_master lsh_lin_master_i (.mclk(mclk), .sin(sin));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (rx_out.valid === 1'b1) rxq.push_back(rx_out.data);
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_reg(input logic [5:0] a);
      addr <= a; rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge mclk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #500_000;
      errors++;
      final_report;
   end
   initial begin
      {wr, rd, addr, wdata, errors, n_compared} = '0;
      rst_b = 1'b0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rd_reg(`LSH_ADDR_LIN_CTL); check(v, `LSH_CTL_RESET);
      rd_reg(`LSH_ADDR_BAUD); check(v, `LSH_BAUD_RESET);
      rd_reg(6'h3F); check(v, 32'h0000_0000);
      wr_reg(`LSH_ADDR_IER, 32'h0000_0100);
      wr_reg(`LSH_ADDR_BAUD, 32'h3000_000E);
      foreach (rows[i]) begin
         wr_reg(`LSH_ADDR_LIN_CTL, {16'h000C, rows[i].ctl});
         lsh_lin_master_i.send_header(13, rows[i].sy, rows[i].pid);
         rd_reg(`LSH_ADDR_LIN_SR); check(v & 32'h7, {29'h0, rows[i].flags});
         check({31'h0, irq}, {31'h0, |rows[i].flags});
         wr_reg(`LSH_ADDR_LIN_SR, 32'h0000_000F);
         rd_reg(`LSH_ADDR_LIN_SR); check({v[2:0], irq}, 4'h0);
         $display("header row %0d done", i);
      end
      wr_reg(`LSH_ADDR_LIN_CTL, 32'h000C_0002);
      lsh_lin_master_i.send_header(13, 8'h55, 8'h3C);
      rd_reg(`LSH_ADDR_LIN_SR); check(v & 32'h7, 32'h0);
      wr_reg(`LSH_ADDR_LIN_CTL, 32'h000C_0003);
      lsh_lin_master_i.send_header(10, 8'h55, 8'h3C);
      rd_reg(`LSH_ADDR_LIN_SR); check(v & 32'h7, 32'h0);
      lsh_lin_master_i.hold(1'b0, 13);
      lsh_lin_master_i.hold(1'b1, 60);
      rd_reg(`LSH_ADDR_LIN_SR); check(v & 32'h7, 32'h2);
      wr_reg(`LSH_ADDR_LIN_SR, 32'h0000_000F);
      $display("disable, short break, time-out done");
      for (int h = 0; h < 3; h++) begin
         wr_reg(`LSH_ADDR_LIN_CTL, {8'h3C, h[1:0], 6'h0C, 16'h0013});
         rxq.delete();
         lsh_lin_master_i.send_byte(8'h77);
         lsh_lin_master_i.send_header(13, 8'h55, 8'h3C);
         lsh_lin_master_i.send_byte(8'hA5);
         check(rxq.size() > 0 ? {24'h0, rxq[0]} : 32'hFFFF, h == 0 ? 32'h55 : h == 1 ? 32'h3C : 32'hA5);
         wr_reg(`LSH_ADDR_LIN_SR, 32'h0000_000F);
      end
      $display("mute exits done");
      wr_reg(`LSH_ADDR_LIN_CTL, 32'h000C_0007);
      lsh_lin_master_i.bit_clks = 18;
      lsh_lin_master_i.send_header(13, 8'h55, 8'h3C);
      rd_reg(`LSH_ADDR_BAUD); check(v, 32'h3000_0010);
      rd_reg(`LSH_ADDR_LIN_SR); check(v & 32'h7, 32'h1);
      wr_reg(`LSH_ADDR_LIN_SR, 32'h0000_0007);
      wr_reg(`LSH_ADDR_LIN_CTL, 32'h000C_000F);
      lsh_lin_master_i.send_byte(8'h00);
      rd_reg(`LSH_ADDR_BAUD); check(v, 32'h3000_000E);
      rd_reg(`LSH_ADDR_LIN_CTL); check(v & 32'h8, 32'h0);
      lsh_lin_master_i.bit_clks = 20;
      lsh_lin_master_i.send_header(13, 8'h55, 8'h3C);
      rd_reg(`LSH_ADDR_LIN_SR); check(v & 32'h2, 32'h2);
      wr_reg(`LSH_ADDR_LIN_SR, 32'h0000_000F);
      rd_reg(`LSH_ADDR_BAUD); check(v, 32'h3000_000E);
      $display("resync done");
      final_report;
   end
endmodule // lsh_header_rx_tb
bind lsh_header_rx lsh_header_rx_sva lsh_header_rx_sva_i (.mclk(mclk), .rst_b(rst_b), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sin(sin), .rx_out(rx_out), .irq(irq));
`default_nettype wire
